// file: core/erp_event_record_packer.sv
/*
  Event record packer: forms one 96-bit record per accepted event and
  presents it to the event FIFO write port as a single word.
  Assumes producers hold a request until evt_ready is seen; all inputs
  are synchronous to core_clk.
*/
module erp_event_record_packer
  import erp_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // event request from edge detection / time base
  input wire logic evt_valid,
  input wire logic evt_rising,
  input wire logic [15:0] evt_ident,
  input wire logic [15:0] snapshot_values,
  input wire logic is_snapshot,
  input wire logic is_overflow,
  input wire logic is_chan_fault,
  input wire logic applicative_mode,
  // time base
  input wire logic [31:0] epoch_seconds_field,
  input wire logic [23:0] subsecond_fraction_field,
  input wire logic clock_fault_flag,
  input wire logic unsynced_flag,
  input wire logic catchup_start,
  // fifo write side
  input wire logic fifo_ready,
  output logic evt_ready,
  output logic fifo_valid,
  output logic [95:0] fifo_record,
  output logic catchup_active
);

  // ==========================================================
  // helpers
  // ==========================================================
  // 56-bit stamp: seconds above fraction, compared as one number
  function automatic logic [55:0] stamp_of(input logic [31:0] s, input logic [23:0] f);
    stamp_of = {s, f};
  endfunction : stamp_of

  function automatic logic [55:0] stamp_step(input logic [55:0] st);
    logic [24:0] sum;
    sum = {1'b0, st[23:0]} + {1'b0, CATCHUP_STEP_FRAC};
    // a wrapped fraction carries one second up
    if (sum >= FRAC_ONE_SEC) begin
      stamp_step = {st[55:24] + 32'h00000001, 24'(sum - FRAC_ONE_SEC)};
    end else begin
      stamp_step = {st[55:24], sum[23:0]};
    end
  endfunction : stamp_step

  // byte n of a field; every multi-byte field goes low byte first
  function automatic logic [7:0] byte_of(input logic [31:0] w, input int n);
    byte_of = w[n*8 +: 8];
  endfunction : byte_of

  // ==========================================================
  // handshake
  // ==========================================================
  logic fifo_valid_r;
  logic evt_ready_r;
  logic take;
  logic slot_free;

  // one record in flight at a time keeps records indivisible
  assign take = evt_valid && evt_ready_r;
  // the word slot is free when empty or when the fifo takes it now;
  // ready is a flop, so a request waits one cycle longer than needed
  assign slot_free = !fifo_valid_r || fifo_ready;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_ready_r <= 1'b0;
    end else if (clk_en) begin
      evt_ready_r <= !take && slot_free;
    end
  end

  // ==========================================================
  // catch-up state
  // ==========================================================
  erp_state_t state_r;
  erp_state_t state_nxt;
  logic [55:0] last_stamp_r;
  logic [55:0] live_stamp;
  logic [55:0] step_stamp;
  logic [55:0] use_stamp;
  logic in_catchup;
  logic live_later;

  // ==========================================================
  // stamp source
  // ==========================================================
  // the last stamp is kept even while live, ready for a catch-up
  assign live_stamp = stamp_of(epoch_seconds_field, subsecond_fraction_field);
  assign step_stamp = stamp_step(last_stamp_r);
  // equal times keep catch-up on: two stamps in a row must differ
  assign live_later = live_stamp > last_stamp_r;
  assign in_catchup = (state_r == ERP_ST_CATCHUP) && !live_later;

  assign use_stamp = in_catchup ? step_stamp : live_stamp;

  // ==========================================================
  // catch-up state machine
  // ==========================================================
  // leave on first later time
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ERP_ST_LIVE: begin
        // a start while live always begins catch-up
        if (catchup_start) begin
          state_nxt = ERP_ST_CATCHUP;
        end
      end
      ERP_ST_CATCHUP: begin
        if (take && !in_catchup) begin
          state_nxt = ERP_ST_LIVE;
        end
      end
      default: state_nxt = ERP_ST_LIVE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ERP_ST_LIVE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // stamp register
  // ==========================================================
  // previous stamp kept
  // only taken records move it; a refused request leaves no trace
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_stamp_r <= 56'h00000000000000;
    end else if (clk_en && take) begin
      last_stamp_r <= use_stamp;
    end
  end

  // ==========================================================
  // record assembly
  // ==========================================================
  logic [4:0] precision_code;
  logic [7:0] quality_byte;
  logic [7:0] value_byte;
  logic [15:0] ident_word;
  logic [95:0] record_nxt;
  logic [31:0] sec_word;
  logic [23:0] frac_word;
  // field lengths in bytes follow from where the next field starts
  localparam int ID_BYTES = BYTE_SEC_LO - BYTE_ID_LO;
  localparam int SEC_BYTES = BYTE_FRAC_LO - BYTE_SEC_LO;
  localparam int FRAC_BYTES = BYTE_QUAL - BYTE_FRAC_LO;

  // ==========================================================
  // precision code
  // ==========================================================
  // code priority order
  // specials beat catch-up: a reader must learn why the record is odd
  always_comb begin
    if (is_chan_fault) begin
      precision_code = PREC_CHAN_FAULT;
    end else if (is_overflow) begin
      precision_code = PREC_OVERFLOW;
    end else if (is_snapshot) begin
      precision_code = PREC_SNAPSHOT;
    end else if (in_catchup) begin
      precision_code = PREC_CATCHUP;
    end else begin
      // normal code regardless of clock status
      precision_code = PREC_NORMAL;
    end
  end

  // ==========================================================
  // quality byte
  // ==========================================================
  // quality byte layout
  // status flags pass through as seen at the take edge
  always_comb begin
    quality_byte = {3'b000, precision_code};
    quality_byte[QB_LEAP] = 1'b0;
    quality_byte[QB_FAULT] = clock_fault_flag;
    quality_byte[QB_UNSYNC] = unsynced_flag;
  end

  // ==========================================================
  // value and identifier
  // ==========================================================
  // value byte, snapshot carries channel values in id slot too
  // only eight channel values fit the value byte; the upper eight ride in
  // the identifier bytes so all sixteen survive in one record, except when an applicative overflow takes the identifier
  always_comb begin
    if (is_snapshot) begin
      value_byte = snapshot_values[7:0];
    end else begin
      value_byte = {7'b0000000, evt_rising};
    end
  end

  // overflow identifier in applicative mode
  // applicative overflow wins so its marker never reads as a channel
  always_comb begin
    if (is_overflow && applicative_mode) begin
      ident_word = OVERFLOW_MARKER_IDENT;
    end else if (is_snapshot) begin
      ident_word = {8'h00, snapshot_values[15:8]};
    end else begin
      ident_word = evt_ident;
    end
  end

  assign sec_word = use_stamp[55:24];
  assign frac_word = use_stamp[23:0];

  // ==========================================================
  // record packing
  // ==========================================================
  // twelve byte layout
  always_comb begin
    record_nxt = '0;
    record_nxt[BYTE_RSVD*8 +: 8] = RSVD_BYTE_VAL[7:0];
    record_nxt[BYTE_VALUE*8 +: 8] = value_byte;
    for (int i = 0; i < ID_BYTES; i++) begin
      record_nxt[(BYTE_ID_LO + i)*8 +: 8] = byte_of({16'h0000, ident_word}, i);
    end
    for (int i = 0; i < SEC_BYTES; i++) begin
      record_nxt[(BYTE_SEC_LO + i)*8 +: 8] = byte_of(sec_word, i);
    end
    for (int i = 0; i < FRAC_BYTES; i++) begin
      record_nxt[(BYTE_FRAC_LO + i)*8 +: 8] = byte_of({8'h00, frac_word}, i);
    end
    record_nxt[BYTE_QUAL*8 +: 8] = quality_byte;
  end

  // ==========================================================
  // output register
  // ==========================================================
  logic [95:0] record_r;
  logic catchup_r;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fifo_valid_r <= 1'b0;
    end else if (clk_en) begin
      // a new take wins over the fifo emptying the slot
      if (take) begin
        fifo_valid_r <= 1'b1;
      end else if (fifo_ready) begin
        fifo_valid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      record_r <= '0;
    end else if (clk_en && take) begin
      record_r <= record_nxt;
    end
  end

  // ==========================================================
  // catch-up flag
  // ==========================================================
  // mirrors the next state so the flag and state_r always agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      catchup_r <= 1'b0;
    end else if (clk_en) begin
      catchup_r <= (state_nxt == ERP_ST_CATCHUP);
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  // every output leaves straight from a flop
  assign fifo_valid = fifo_valid_r;
  assign fifo_record = record_r;
  assign evt_ready = evt_ready_r;
  assign catchup_active = catchup_r;

endmodule : erp_event_record_packer

// file: core/erp_pkg.sv
/*
  Constants for the event record packer: record byte layout, quality byte
  fields, precision codes and catch-up timing.
  Assumes a single 125 MHz core clock and producers synchronous to it.
*/
package erp_pkg;
  localparam int REC_BYTES = 12;
  localparam int REC_W = REC_BYTES * 8;
  // byte positions within the record
  localparam int BYTE_RSVD = 0;
  localparam int BYTE_VALUE = 1;
  localparam int BYTE_ID_LO = 2;
  localparam int BYTE_SEC_LO = 4;
  localparam int BYTE_FRAC_LO = 8;
  localparam int BYTE_QUAL = 11;
  // quality byte fields
  localparam int QB_LEAP = 7;
  localparam int QB_FAULT = 6;
  localparam int QB_UNSYNC = 5;
  localparam logic [4:0] PREC_NORMAL = 5'h0A;
  localparam logic [4:0] PREC_OVERFLOW = 5'h1E;
  localparam logic [4:0] PREC_CHAN_FAULT = 5'h1D;
  localparam logic [4:0] PREC_SNAPSHOT = 5'h1C;
  localparam logic [4:0] PREC_CATCHUP = 5'h1B;
  localparam logic [15:0] OVERFLOW_MARKER_IDENT = 16'h0010;
  // catch-up step: 0.5 ms as a 24-bit fraction of a second, rounded down
  localparam real CATCHUP_STEP_MS = 0.5;
  localparam logic [24:0] FRAC_ONE_SEC = 25'h1000000;
  localparam logic [23:0] CATCHUP_STEP_FRAC =
    24'(int'($floor(CATCHUP_STEP_MS / 1000.0 * 16777216.0)));
  localparam logic [23:0] RSVD_BYTE_VAL = 24'h000000;
  typedef enum logic [1:0] {
    ERP_ST_LIVE = 2'b01,
    ERP_ST_CATCHUP = 2'b10
  } erp_state_t;
endpackage : erp_pkg

// file: verif/erp_event_record_packer_tb.sv
/* Self-checking bench for the record packer.
   Assumes the fifo model and the bound monitor. */
module erp_event_record_packer_tb import erp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, arst_n = 0, clk_en = 1, evt_valid = 0, evt_rising = 0, slow = 0;
  logic [15:0] evt_ident = '0, snapshot_values = '0;
  logic is_snapshot = 0, is_overflow = 0, is_chan_fault = 0, applicative_mode = 0;
  logic [31:0] epoch_seconds_field = '0;
  logic [23:0] subsecond_fraction_field = '0;
  logic clock_fault_flag = 0, unsynced_flag = 0, catchup_start = 0;
  logic fifo_ready, evt_ready, fifo_valid, catchup_active;
  logic [95:0] fifo_record;
  logic [95:0] exp_q[$];
  logic [55:0] last_st = '0;
  bit cu = 0;
  int n_fail = 0, n_compared = 0, cyc = 0;
  erp_event_record_packer dut (.*);
  erp_fifo_sink u_sink (.core_clk, .slow, .fifo_ready);
  initial forever #4 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // ==========
  // one event, expected record noted first
  task automatic send(input bit sn, ov, cf, am, input logic [55:0] t);
    logic [55:0] st;
    logic [4:0] c;
    logic [15:0] id;
    @(posedge core_clk) #1;
    {clock_fault_flag, unsynced_flag, evt_rising, evt_ident} = 19'($urandom);
    snapshot_values = 16'($urandom);
    {is_snapshot, is_overflow, is_chan_fault, applicative_mode} = {sn, ov, cf, am};
    {epoch_seconds_field, subsecond_fraction_field} = t;
    st = (cu && t <= last_st) ? last_st + 56'(CATCHUP_STEP_FRAC) : t;
    c = cf ? PREC_CHAN_FAULT : ov ? PREC_OVERFLOW : sn ? PREC_SNAPSHOT : PREC_NORMAL;
    if (!cf && !ov && !sn && st != t) c = PREC_CATCHUP;
    cu = cu && st != t;
    last_st = st;
    id = sn ? {8'h00, snapshot_values[15:8]} : (ov && am) ? OVERFLOW_MARKER_IDENT : evt_ident;
    exp_q.push_back({1'b0, clock_fault_flag, unsynced_flag, c, st[23:0], st[55:24], id,
      sn ? snapshot_values[7:0] : {7'h00, evt_rising}, 8'h00});
    evt_valid = 1;
    while (evt_ready !== 1'b1) @(posedge core_clk) #1;
    @(posedge core_clk) #1;
    evt_valid = 0;
  endtask : send
  // the sink takes the word at the next edge
  always @(negedge core_clk) begin
    if (arst_n && clk_en && fifo_valid === 1'b1 && fifo_ready === 1'b1) begin
      if (exp_q.size() == 0) chk("extra record", fifo_record, 'x);
      else chk("record", fifo_record, exp_q.pop_front());
    end
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    void'($urandom(76290));
    repeat (4) @(posedge core_clk);
    #1 arst_n = 1;
    repeat (24) begin
      slow = 1'($urandom);
      send(0, 0, 0, 0, {$urandom, 24'($urandom)});
    end
    $display("plain traffic done");
    // every kind and mode, snapshot with overflow left out
    for (int k = 0; k < 16; k++) if (!(k[0] && k[1])) send(k[0], k[1], k[2], k[3], {$urandom, 24'h000000});
    $display("record kinds done");
    // a low enable freezes a waiting word and the refusal
    send(0, 0, 0, 0, {$urandom, 24'($urandom)});
    clk_en = 0;
    repeat (3) @(posedge core_clk) #1;
    chk("frozen valid ready", 96'({fifo_valid, evt_ready}), 96'h2);
    clk_en = 1;
    $display("enable freeze done");
    send(0, 0, 0, 0, 56'h00000100_FFF000);
    catchup_start = 1;
    @(posedge core_clk) #1;
    catchup_start = 0;
    chk("catchup on", 96'(catchup_active), 96'h1);
    cu = 1;
    send(0, 0, 0, 0, 56'h0);
    // a special kind in catch-up keeps its own code but a stepped stamp
    send(1, 0, 0, 1, 56'h0);
    send(0, 0, 0, 0, 56'h00000200_000000);
    chk("catchup off", 96'(catchup_active), 96'h0);
    while (exp_q.size() != 0) @(posedge core_clk);
    $display("catch-up done");
    summarize();
  end
endmodule : erp_event_record_packer_tb

// file: verif/erp_fifo_sink.sv
/* Event FIFO model at the packer's far side.
   Assumes core_clk; slow takes a word one cycle in three. */
module erp_fifo_sink (
  input wire logic core_clk,
  input wire logic slow,
  output logic fifo_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_r = 2'h0;
  initial fifo_ready = 1'b0;
  always @(posedge core_clk) begin
    cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
    fifo_ready <= #1 !slow || cnt_r == 2'h0;
  end
endmodule : erp_fifo_sink

// file: verif/erp_monitor.sv
/* Port assertions for the record packer.
   Assumes one clock domain; bound to the packer below. */
module erp_monitor
  import erp_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic evt_valid,
  input wire logic evt_rising,
  input wire logic [15:0] evt_ident,
  input wire logic is_snapshot,
  input wire logic is_overflow,
  input wire logic is_chan_fault,
  input wire logic applicative_mode,
  input wire logic [31:0] epoch_seconds_field,
  input wire logic [23:0] subsecond_fraction_field,
  input wire logic clock_fault_flag,
  input wire logic unsynced_flag,
  input wire logic catchup_start,
  input wire logic fifo_ready,
  input wire logic evt_ready,
  input wire logic fifo_valid,
  input wire logic [95:0] fifo_record,
  input wire logic catchup_active
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire live = !catchup_active && !catchup_start;
  wire kind = is_snapshot || is_overflow || is_chan_fault;
  // ==========
  // steps
  sequence s_take;
    clk_en && evt_valid && evt_ready;
  endsequence
  sequence s_stall;
    fifo_valid && !(clk_en && fifo_ready);
  endsequence
  a_take_refuse: assert property (s_take |=> fifo_valid && !evt_ready)
    else $error("no refusal after take");
  a_word_holds: assert property (s_stall |=> fifo_valid && $stable(fifo_record))
    else $error("record moved while stalled");
  a_rsvd_leap: assert property (fifo_valid |-> !fifo_record[95] && fifo_record[7:0] == 8'h00)
    else $error("reserved or leap bit set");
  a_time_copy: assert property (s_take ##0 live |=>
    fifo_record[63:32] == $past(epoch_seconds_field) &&
    fifo_record[87:64] == $past(subsecond_fraction_field)) else $error("stamp wrong");
  a_flag_copy: assert property (s_take |=>
    fifo_record[94:93] == {$past(clock_fault_flag), $past(unsynced_flag)}) else $error("flags");
  a_chan_code: assert property (s_take ##0 is_chan_fault |=>
    fifo_record[92:88] == PREC_CHAN_FAULT) else $error("channel code");
  a_norm_code: assert property (s_take ##0 (live && !kind) |=>
    fifo_record[92:88] == PREC_NORMAL) else $error("normal code");
  a_edge_ident: assert property (s_take ##0 !(is_snapshot || is_overflow) |=>
    fifo_record[8] == $past(evt_rising) && fifo_record[31:16] == $past(evt_ident))
    else $error("edge or ident");
  a_ovf_ident: assert property (s_take ##0 (is_overflow && applicative_mode)
    |=> fifo_record[31:16] == OVERFLOW_MARKER_IDENT) else $error("overflow ident");
  a_ovf_code: assert property (s_take ##0 (is_overflow && !is_chan_fault) |=>
    fifo_record[92:88] == PREC_OVERFLOW) else $error("overflow code");
  a_snap_code: assert property (s_take ##0 is_snapshot
    ##0 !(is_overflow || is_chan_fault) |=> fifo_record[92:88] == PREC_SNAPSHOT)
    else $error("snapshot code");
endmodule : erp_monitor

bind erp_event_record_packer erp_monitor u_mon (.*);
